// [verilog/parity_csr_map.vh]
// Purpose: constants for the parity control/status register block
// Assumes: 18-bit bus address, octal register window 772100..772136
// Notes:   included by every design file of the block
`ifndef PARITY_CSR_MAP_VH
`define PARITY_CSR_MAP_VH

// register window: upper bits hardwired, A04..A01 from straps
`define CSR_BASE_ADDR     18'h3F440
`define CSR_ADDR_HI_MSB   17
`define CSR_ADDR_HI_LSB   5
`define CSR_ADDR_SEL_MSB  4
`define CSR_ADDR_SEL_LSB  1
`define CSR_WIDTH         16

// field positions
`define CSR_ERR_BIT       15
`define CSR_EADDR_MSB     11
`define CSR_EADDR_LSB     5
`define CSR_EADDR_W       7
`define CSR_WEVEN_BIT     2
`define CSR_ENABLE_BIT    0

// reset values
`define CSR_EADDR_RST     7'h00

// timing: check delay and restore pulse
`define CHECK_DLY_NS      200
`define RESTORE_PULSE_NS  500
`define CLK_PERIOD_NS     40

`endif

// [verilog/byte_parity_gen.v]
// Purpose: odd parity bit for one data byte
// Assumes: purely combinational
// Notes:   output is 1 when the byte holds an even number of ones and invert is low
`include "parity_csr_map.vh"

module byte_parity_gen
#(
  parameter WIDTH = 8
)
(
  input  wire [WIDTH-1:0] data,
  input  wire             invert,
  output wire             parity
);

  // odd-parity bit, optionally inverted for diagnostics
  assign parity = ~(^data) ^ invert;

endmodule

// [verilog/strobe_sync.v]
// Purpose: three-stage synchroniser for an asynchronous pin
// Assumes: change accepted once stages two and three agree
// Notes:   first stage is read only by the second stage
`include "parity_csr_map.vh"

module strobe_sync
#(
  parameter RESET_VAL = 1'b1
)
(
  input  wire clk,
  input  wire srst,
  input  wire ce,
  input  wire pin,
  output reg  level
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // shift chain, level updates only when stages agree
  always @(posedge clk)
  begin
    if (srst)
    begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
      level  <= RESET_VAL;
    end
    else if (ce)
    begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        level <= s3_reg;
    end
  end

endmodule

// [verilog/parity_csr_bus_interface.v]
// Overview of operation
// - one 16-bit control/status register, written as a whole word or by byte
// - one such register serves each 32K-word span of memory
// - bit 15 sets on every parity error, whatever else is enabled
// - bit 15 is a read/write flag and raises no trap
// - bits 11:5 hold high address bits of the latest failing location
// - bit 2 set makes writes store wrong (even) parity for diagnostics
// - bit 0 set reports parity errors to the bus master; clear sends none
// - register decoded at one word address inside 772100..772136 octal
// - four straps give address bits A01..A04; installed strap gives 0
// - addresses assigned per 8K start boundary, sixteen distinct addresses
// - low read-data strobe from memory starts the parity check sequence
// - high-byte parity line two-way, covers D15:D08
// - low-byte parity line two-way, covers D07:D00
// - parity error on read-with-pause pulses low restore trigger line
// - error report drives PB parity line while PA stays deasserted
// - odd parity per byte: even count of ones writes a 1
//
// Purpose: parity controller register and internal-bus sequencing
// Assumes: bus pins arrive asynchronously; 25 MHz clk; bus_init on srst domain
// Notes:   internal parity lines are open drain, active low; oe low drives
`include "parity_csr_map.vh"

module parity_csr_bus_interface
#(
  parameter CLK_NS  = `CLK_PERIOD_NS,
  parameter CHK_NS  = `CHECK_DLY_NS,
  parameter RST_NS  = `RESTORE_PULSE_NS
)
(
  input  wire        clk,
  input  wire        srst,
  input  wire        ce,
  input  wire        bus_init,
  input  wire [17:0] bus_addr,
  input  wire [15:0] bus_data_in,
  input  wire        bus_msyn_n,
  input  wire        bus_write,
  input  wire        bus_byte,
  input  wire        bus_pause,
  input  wire        addr_strap_bit1,
  input  wire        addr_strap_bit2,
  input  wire        addr_strap_bit3,
  input  wire        addr_strap_bit4,
  input  wire        read_data_present_strobe_n,
  input  wire        high_byte_check_line_in,
  input  wire        low_byte_check_line_in,
  output reg         high_byte_check_line_out,
  output reg         high_byte_check_line_oe_n,
  output reg         low_byte_check_line_out,
  output reg         low_byte_check_line_oe_n,
  output reg         restore_trigger_pulse_n,
  output reg  [15:0] bus_data_out,
  output reg         bus_data_oe,
  output reg         bus_ssyn_n,
  output reg         bus_pb_n,
  output reg         bus_pa_n
);

  // --------------------------------------------------------------
  // timing counts
  // --------------------------------------------------------------
  localparam integer CHK_INT = (CHK_NS + CLK_NS - 1) / CLK_NS;
  localparam integer RST_INT = (RST_NS / CLK_NS < 1) ? 1 : RST_NS / CLK_NS;
  localparam [7:0]   CHK_CYC = CHK_INT[7:0];
  localparam [7:0]   RST_CYC = RST_INT[7:0];

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_DELAY = 3'h1;
  localparam [2:0] ST_JUDGE = 3'h2;
  localparam [2:0] ST_REST  = 3'h3;
  localparam [2:0] ST_DONE  = 3'h4;

  // --------------------------------------------------------------
  // synchronised inputs
  // --------------------------------------------------------------
  wire msyn_n_s;
  wire rdp_n_s;

  strobe_sync #(.RESET_VAL(1'b1)) u_msyn
  (
    .clk   (clk),
    .srst  (srst),
    .ce    (ce),
    .pin   (bus_msyn_n),
    .level (msyn_n_s)
  );

  strobe_sync #(.RESET_VAL(1'b1)) u_rdp
  (
    .clk   (clk),
    .srst  (srst),
    .ce    (ce),
    .pin   (read_data_present_strobe_n),
    .level (rdp_n_s)
  );

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  reg                      err_reg;
  reg [`CSR_EADDR_W-1:0]   eaddr_reg;
  reg                      weven_reg;
  reg                      enable_reg;
  reg [2:0]                state_reg;
  reg [7:0]                cnt_reg;
  reg                      msyn_d_reg;
  reg                      rdp_d_reg;
  reg                      csr_hit_reg;

  // --------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------
  wire [3:0] strap_sel;
  wire       csr_sel;
  wire       msyn_fall;
  wire       rdp_fall;
  wire       par_err;
  wire       hi_par;
  wire       lo_par;

  // installed strap (pin low) gives address bit 0
  assign strap_sel = {addr_strap_bit4, addr_strap_bit3,
                      addr_strap_bit2, addr_strap_bit1};
  assign csr_sel = (bus_addr[`CSR_ADDR_HI_MSB:`CSR_ADDR_HI_LSB] ==
                    `CSR_BASE_ADDR >> `CSR_ADDR_HI_LSB)
                   && (bus_addr[`CSR_ADDR_SEL_MSB:`CSR_ADDR_SEL_LSB] == strap_sel)
                   && (!bus_addr[0] || (bus_write && bus_byte));
  assign msyn_fall = msyn_d_reg && !msyn_n_s;
  assign rdp_fall  = rdp_d_reg && !rdp_n_s;

  // check: byte plus its parity bit must hold odd count (lines active low)
  assign par_err = ~(^{bus_data_in[15:8], ~high_byte_check_line_in}) |
                   ~(^{bus_data_in[7:0],  ~low_byte_check_line_in});

  // --------------------------------------------------------------
  // parity generators
  // --------------------------------------------------------------
  byte_parity_gen #(.WIDTH(8)) u_hi
  (
    .data   (bus_data_in[15:8]),
    .invert (weven_reg),
    .parity (hi_par)
  );

  byte_parity_gen #(.WIDTH(8)) u_lo
  (
    .data   (bus_data_in[7:0]),
    .invert (weven_reg),
    .parity (lo_par)
  );

  // --------------------------------------------------------------
  // edge history
  // --------------------------------------------------------------
  always @(posedge clk)
  begin
    if (srst)
    begin
      msyn_d_reg <= 1'b1;
      rdp_d_reg  <= 1'b1;
    end
    else if (ce)
    begin
      msyn_d_reg <= msyn_n_s;
      rdp_d_reg  <= rdp_n_s;
    end
  end

  // --------------------------------------------------------------
  // register access and error capture
  // --------------------------------------------------------------
  always @(posedge clk)
  begin
    if (srst || (ce && bus_init))
    begin
      err_reg     <= 1'b0;
      eaddr_reg   <= `CSR_EADDR_RST;
      weven_reg   <= 1'b0;
      enable_reg  <= 1'b0;
      csr_hit_reg <= 1'b0;
      bus_data_out <= 16'h0000;
      bus_data_oe  <= 1'b0;
    end
    else if (ce)
    begin
      if (msyn_fall && csr_sel)
      begin
        csr_hit_reg <= 1'b1;
        if (bus_write)
        begin
          // full control word write; even byte write loads bits 11:0, odd byte write bit 15
          if (!bus_byte || !bus_addr[0])
          begin
            weven_reg  <= bus_data_in[`CSR_WEVEN_BIT];
            enable_reg <= bus_data_in[`CSR_ENABLE_BIT];
            eaddr_reg  <= bus_data_in[`CSR_EADDR_MSB:`CSR_EADDR_LSB];
          end
          if (!bus_byte || bus_addr[0])
            err_reg <= bus_data_in[`CSR_ERR_BIT];
        end
        else
        begin
          bus_data_out <= 16'h0000;
          bus_data_out[`CSR_ERR_BIT] <= err_reg;
          bus_data_out[`CSR_EADDR_MSB:`CSR_EADDR_LSB] <= eaddr_reg;
          bus_data_out[`CSR_WEVEN_BIT] <= weven_reg;
          bus_data_out[`CSR_ENABLE_BIT] <= enable_reg;
          bus_data_oe <= 1'b1;
        end
      end
      else if (msyn_n_s)
      begin
        csr_hit_reg <= 1'b0;
        bus_data_oe <= 1'b0;
      end
      // error capture wins over a same-cycle register write
      if (state_reg == ST_JUDGE && par_err)
      begin
        err_reg   <= 1'b1;
        eaddr_reg <= bus_addr[`CSR_ADDR_HI_MSB:`CSR_ADDR_HI_MSB-`CSR_EADDR_W+1];
      end
    end
  end

  // --------------------------------------------------------------
  // check sequence and internal bus drive
  // --------------------------------------------------------------
  always @(posedge clk)
  begin
    if (srst || (ce && bus_init))
    begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 8'h00;
      high_byte_check_line_out  <= 1'b1;
      high_byte_check_line_oe_n <= 1'b1;
      low_byte_check_line_out   <= 1'b1;
      low_byte_check_line_oe_n  <= 1'b1;
      restore_trigger_pulse_n   <= 1'b1;
      bus_ssyn_n <= 1'b1;
      bus_pb_n   <= 1'b1;
      bus_pa_n   <= 1'b1;
    end
    else if (ce)
    begin
      bus_pa_n <= 1'b1;
      // drive generated parity to memory on writes; line low means 1
      if (!msyn_n_s && bus_write && !csr_sel)
      begin
        high_byte_check_line_out  <= ~hi_par;
        low_byte_check_line_out   <= ~lo_par;
        high_byte_check_line_oe_n <= 1'b0;
        low_byte_check_line_oe_n  <= 1'b0;
      end
      else
      begin
        high_byte_check_line_oe_n <= 1'b1;
        low_byte_check_line_oe_n  <= 1'b1;
      end
      // register access handshake
      if (csr_hit_reg && !msyn_n_s)
        bus_ssyn_n <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (rdp_fall && !bus_write)
          begin
            state_reg <= ST_DELAY;
            cnt_reg   <= CHK_CYC;
          end
          else if (msyn_n_s)
          begin
            bus_ssyn_n <= 1'b1;
            bus_pb_n   <= 1'b1;
          end
        end
        ST_DELAY:
        begin
          if (cnt_reg <= 8'h01)
            state_reg <= ST_JUDGE;
          else
            cnt_reg <= cnt_reg - 8'h01;
        end
        ST_JUDGE:
        begin
          bus_ssyn_n <= 1'b0;
          if (par_err && enable_reg)
            bus_pb_n <= 1'b0;
          if (par_err && bus_pause)
          begin
            restore_trigger_pulse_n <= 1'b0;
            cnt_reg   <= RST_CYC;
            state_reg <= ST_REST;
          end
          else
            state_reg <= ST_DONE;
        end
        ST_REST:
        begin
          if (cnt_reg <= 8'h01)
          begin
            restore_trigger_pulse_n <= 1'b1;
            state_reg <= ST_DONE;
          end
          else
            cnt_reg <= cnt_reg - 8'h01;
        end
        ST_DONE:
        begin
          if (msyn_n_s)
          begin
            bus_ssyn_n <= 1'b1;
            bus_pb_n   <= 1'b1;
            state_reg  <= ST_IDLE;
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule

// [sim/mem_partner.sv]
// Purpose: memory timing side of the private parity bus
// Assumes: open-drain check lines with pull-ups, low level is parity one
// Notes:   strobe answers memory reads only (sel high), after dly+1 cycles
module mem_partner
(
  input  logic        clk,
  input  logic        sel,
  input  logic        msyn_n,
  input  logic        write,
  input  logic [3:0]  dly,
  input  logic [15:0] data,
  input  logic [1:0]  bad,
  input  logic        hi_out,
  input  logic        hi_oe_n,
  input  logic        lo_out,
  input  logic        lo_oe_n,
  output logic        strobe_n,
  output logic        hi_line,
  output logic        lo_line
);
  timeunit 1ns;
  timeprecision 1ns;
  int   wait_cnt = 0;
  logic drv;
  // read access delay, restarts whenever the master lets go
  always @(posedge clk)
    if (msyn_n || write || !sel)
      wait_cnt <= 0;
    else if (wait_cnt <= dly)
      wait_cnt <= wait_cnt + 1;
  assign drv = sel && !msyn_n && !write && wait_cnt > dly;
  assign strobe_n = !drv;
  // wired lines: controller, then memory, else pull-up
  assign hi_line = !hi_oe_n ? hi_out : drv ? ^data[15:8] ^ bad[1] : 1'b1;
  assign lo_line = !lo_oe_n ? lo_out : drv ? ^data[7:0] ^ bad[0] : 1'b1;
endmodule

// [sim/parity_csr_asserts.sv]
// Purpose: port checker for the parity register block
// Assumes: one clock, srst or bus_init clears the sequence
// Notes:   attached by bind to every instance
module parity_csr_asserts
#(
  parameter CLK_NS = 40,
  parameter RST_NS = 500
)
(
  input logic        clk,
  input logic        srst,
  input logic        bus_init,
  input logic [17:0] bus_addr,
  input logic        bus_msyn_n,
  input logic        bus_write,
  input logic        bus_pause,
  input logic        addr_strap_bit1,
  input logic        addr_strap_bit2,
  input logic        addr_strap_bit3,
  input logic        addr_strap_bit4,
  input logic        read_data_present_strobe_n,
  input logic        high_byte_check_line_oe_n,
  input logic        low_byte_check_line_oe_n,
  input logic        restore_trigger_pulse_n,
  input logic        bus_ssyn_n,
  input logic        bus_pb_n,
  input logic        bus_pa_n
);
  logic [17:0] csr_addr;
  logic [7:0]  low_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (srst || bus_init);
  // strapped register address
  assign csr_addr = 18'h3F440 | {13'h0000, addr_strap_bit4, addr_strap_bit3,
                                 addr_strap_bit2, addr_strap_bit1, 1'b0};
  // length of the restore pulse
  always_ff @(posedge clk)
    if (srst || bus_init || restore_trigger_pulse_n)
      low_cnt <= 8'h00;
    else
      low_cnt <= low_cnt + 8'h01;
  sequence s_csr_req;
    $fell(bus_msyn_n) && bus_addr == csr_addr;
  endsequence
  sequence s_data_ready;
    $fell(read_data_present_strobe_n) && !bus_msyn_n;
  endsequence
  AST_PA_IDLE: assert property (bus_pa_n)
    else $error("pa line asserted");
  AST_PB_WITH_SSYN: assert property (!bus_pb_n |-> !bus_ssyn_n)
    else $error("pb without ssyn");
  AST_SSYN_STANDS: assert property (!bus_msyn_n && !bus_ssyn_n |=> !bus_ssyn_n)
    else $error("ssyn dropped early");
  AST_SSYN_RELEASE: assert property ($rose(bus_msyn_n) |-> ##[1:8] bus_ssyn_n)
    else $error("ssyn not released");
  AST_CSR_ANSWER: assert property (s_csr_req |-> ##[2:8] !bus_ssyn_n)
    else $error("register access not answered");
  AST_CHECK_WAIT: assert property (s_data_ready |-> bus_ssyn_n[*4] ##[1:12] !bus_ssyn_n)
    else $error("check sequence timing wrong");
  AST_RESTORE_LEN: assert property ($rose(restore_trigger_pulse_n) |-> low_cnt == RST_NS / CLK_NS)
    else $error("restore pulse length wrong");
  AST_RESTORE_CAUSE: assert property ($fell(restore_trigger_pulse_n) |-> bus_pause && !bus_write)
    else $error("restore pulse outside paused read");
  AST_DRIVE_ON_WRITE: assert property (!high_byte_check_line_oe_n || !low_byte_check_line_oe_n |-> bus_write)
    else $error("check line driven on read");
  AST_LINES_TOGETHER: assert property ($fell(high_byte_check_line_oe_n) |-> $fell(low_byte_check_line_oe_n))
    else $error("check lines not driven together");
endmodule

bind parity_csr_bus_interface parity_csr_asserts #(.CLK_NS(CLK_NS), .RST_NS(RST_NS)) u_chk (.*);

// [sim/testbench.sv]
// Purpose: self-checking bench for the parity register block
// Assumes: straps random but static, ce held high
// Notes:   check delay 80 ns and restore pulse 160 ns to keep counts small
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RCYC = 4;
  logic        clk = 0, srst = 1, bus_init = 0, msyn_n = 1, wr = 0, pause = 0;
  logic [17:0] addr = 18'h00000, csr_a, a;
  logic [15:0] din = 16'h0000, dout, got, d;
  logic [3:0]  strap = 4'h0, dly = 4'h0;
  logic [1:0]  bad = 2'h0;
  logic        strobe_n, hi_in, lo_in, hi_out, hi_oe_n, lo_out, lo_oe_n;
  logic        rst_n, ssyn_n, pb_n, pa_n, pbv, pav, hiv, lov, doe, oev, byt = 0;
  int          seed = 32'hc41d, err_total = 0, n_tests = 0, cycles = 0, rcnt = 0;
  int          csr_m = 0;
  always #20 clk = ~clk;
  parity_csr_bus_interface #(.CHK_NS(80), .RST_NS(160)) u_dut (.clk(clk), .srst(srst),
    .ce(1'b1), .bus_init(bus_init), .bus_addr(addr), .bus_data_in(din), .bus_msyn_n(msyn_n),
    .bus_write(wr), .bus_byte(byt), .bus_pause(pause), .addr_strap_bit1(strap[0]),
    .addr_strap_bit2(strap[1]), .addr_strap_bit3(strap[2]), .addr_strap_bit4(strap[3]),
    .read_data_present_strobe_n(strobe_n), .high_byte_check_line_in(hi_in),
    .low_byte_check_line_in(lo_in), .high_byte_check_line_out(hi_out),
    .high_byte_check_line_oe_n(hi_oe_n), .low_byte_check_line_out(lo_out),
    .low_byte_check_line_oe_n(lo_oe_n), .restore_trigger_pulse_n(rst_n),
    .bus_data_out(dout), .bus_data_oe(doe), .bus_ssyn_n(ssyn_n), .bus_pb_n(pb_n),
    .bus_pa_n(pa_n));
  mem_partner u_mem (.clk(clk), .sel(addr < 18'h3E000), .msyn_n(msyn_n), .write(wr),
    .dly(dly), .data(din),
    .bad(bad), .hi_out(hi_out), .hi_oe_n(hi_oe_n), .lo_out(lo_out), .lo_oe_n(lo_oe_n),
    .strobe_n(strobe_n), .hi_line(hi_in), .lo_line(lo_in));
  task automatic stop_test;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // cycle count, restore pulse width and hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (!rst_n)
      rcnt++;
    if (cycles == 20000)
    begin
      err_total++;
      stop_test;
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one bus cycle: kind 0 register, 1 memory write, 2 memory read
  task automatic cyc(input logic [17:0] ca, input logic w, input logic [15:0] cd, input int kind);
    int n;
    n = 0;
    @(negedge clk);
    addr = ca;
    wr = w;
    din = cd;
    msyn_n = 0;
    if (kind == 1)
      repeat (8) @(negedge clk);
    else
      while (ssyn_n !== 1'b0 && n < 60)
      begin
        @(negedge clk);
        n++;
      end
    got = dout;
    oev = doe;
    pbv = pb_n;
    pav = pa_n;
    hiv = hi_in;
    lov = lo_in;
    // hold the strobe one more cycle so the answer is seen standing
    if (kind != 1)
      @(negedge clk);
    msyn_n = 1;
    while (ssyn_n !== 1'b1 && n < 60)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 60)
      err_total++;
    repeat (6) @(negedge clk);
  endtask
  // main sequence
  initial
  begin
    strap = $random(seed);
    csr_a = 18'h3F440 | {13'h0000, strap, 1'b0};
    repeat (3) @(negedge clk);
    srst = 0;
    repeat (5) @(negedge clk);
    cyc(csr_a, 0, 16'h0000, 0);
    chk(got, 16'h0000);
    chk(oev, 16'h0001);
    repeat (3)
    begin
      csr_m = $random(seed) & 16'h8FE5;
      cyc(csr_a, 1, csr_m, 0);
      cyc(csr_a, 0, 16'h0000, 0);
      chk(got, csr_m);
    end
    cyc(csr_a ^ 18'h00002, 1, 16'hFFFF, 1);
    cyc(csr_a, 0, 16'h0000, 0);
    chk(got, csr_m);
    // byte writes: even address takes bits 11:0, odd address bit 15
    byt = 1;
    d = $random(seed);
    cyc(csr_a, 1, d, 0);
    csr_m = (csr_m & 16'h8000) | (d & 16'h0FE5);
    d = $random(seed);
    cyc(csr_a | 18'h00001, 1, d, 0);
    csr_m = (csr_m & 16'h0FE5) | (d & 16'h8000);
    byt = 0;
    cyc(csr_a, 0, 16'h0000, 0);
    chk(got, csr_m);
    for (int w = 0; w < 2; w++)
    begin
      csr_m = w << 2;
      cyc(csr_a, 1, csr_m, 0);
      d = $random(seed);
      cyc(18'h00100, 1, d, 1);
      chk(hiv, ^d[15:8] ^ w[0]);
      chk(lov, ^d[7:0] ^ w[0]);
    end
    for (int k = 0; k < 5; k++)
    begin
      csr_m = (csr_m & 16'h8FE0) | (k & 1);
      cyc(csr_a, 1, csr_m, 0);
      a = $random(seed) & 18'h37FFE;
      dly = $random(seed) & 4'h7;
      bad = (k == 4) ? 2'h0 : (k[0] ? 2'h2 : 2'h1);
      pause = k[1];
      rcnt = 0;
      cyc(a, 0, $random(seed), 2);
      chk(pbv, !(bad != 0 && k[0]));
      chk(pav, 1'b1);
      chk(rcnt, (bad != 0 && pause) ? RCYC : 0);
      pause = 0;
      if (bad != 0)
        csr_m = 16'h8000 | (csr_m & 1) | (a[17:11] << 5);
      cyc(csr_a, 0, 16'h0000, 0);
      chk(got, csr_m);
    end
    @(negedge clk);
    bus_init = 1;
    repeat (2) @(negedge clk);
    bus_init = 0;
    repeat (2) @(negedge clk);
    cyc(csr_a, 0, 16'h0000, 0);
    chk(got, 16'h0000);
    stop_test;
  end
endmodule
